// >>> inc/msr_consts.svh
// Register offsets, field positions, field widths, reset values and the forced slave priority of the redundancy block.
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

`define MSR_OFF_MAIN_CONFIG_REG_THREE        8'h00
`define MSR_OFF_MAIN_CONFIG_REG_TEN       8'h04
`define MSR_OFF_INPUT_PRIORITY_REG_SIX        8'h08
`define MSR_OFF_ABW         8'h0c
`define MSR_OFF_LBW         8'h10
`define MSR_OFF_PHASE_MONITOR_REG       8'h14
`define MSR_OFF_OFFSET      8'h18
`define MSR_OFF_EFFECT      8'h1c
`define MSR_OFF_ALIGN       8'h20

`define MSR_MAIN_CONFIG_REG_THREE_REVERTIVE_ENABLE     0
`define MSR_MAIN_CONFIG_REG_THREE_ROLE       1
`define MSR_MAIN_CONFIG_REG_TEN_PHASE_BUILDOUT_ENABLE     0
`define MSR_PHASE_MONITOR_REG_MONITOR_BUILDOUT_ENABLE    0
`define MSR_INPUT_PRIORITY_REG_SIX_INPUT_ELEVEN_PRIORITY_LSB  4
`define MSR_PRI_W           4
`define MSR_BW_W            5
`define MSR_OFS_W           16

`define MSR_RST_MAIN_CONFIG_REG_THREE        2'h0
`define MSR_RST_REVERTIVE_ENABLE      1'b0
`define MSR_RST_PHASE_BUILDOUT_ENABLE       1'b1
`define MSR_RST_MONITOR_BUILDOUT_ENABLE      1'b1
`define MSR_RST_INPUT_PRIORITY_REG_SIX        8'h00
`define MSR_RST_ABW         5'h00
`define MSR_RST_LBW         5'h00
`define MSR_RST_OFFSET      16'h0000
`define MSR_PRI_SLAVE       4'h1

`endif

// >>> inc/msr_pkg.sv
// Types shared by the redundancy control block.
package msr_pkg;
    typedef enum logic [1:0] {
        MSR_ALIGN_NONE,
        MSR_ALIGN_PHASE,
        MSR_ALIGN_FALLING,
        MSR_ALIGN_SUBMULT
    } msr_align_t;

    typedef enum logic {
        MSR_ROLE_SLAVE,
        MSR_ROLE_MASTER
    } msr_role_t;
endpackage

// >>> hdl/msr_role_sync.sv
// Three-stage synchroniser with agreement filter for the role-select pin.
`timescale 1ns/1ps
module msr_role_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    output logic      level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // The level only moves once the last two stages agree.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule

// >>> hdl/msr_redundancy.sv
// Master/slave redundancy control with AHB-Lite register access.
`timescale 1ns/1ps
`include "msr_consts.svh"

module msr_redundancy #(
    parameter int N_OUT = 8,
    parameter int F_W   = 16
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic                    role_select_pin,
    input  wire logic                    main_locked,
    input  wire logic                    aux_locked,
    input  wire logic [F_W-1:0]          ref_freq,
    input  wire logic [N_OUT*F_W-1:0]    out_freq,
    input  wire logic [N_OUT-1:0]        out_from_aux,
    output logic                         role_master_q,
    output logic [`MSR_PRI_W-1:0]        input_eleven_priority_q,
    output logic                         phase_buildout_enable_q,
    output logic                         monitor_buildout_enable_q,
    output logic                         revertive_enable_q,
    output logic [`MSR_BW_W-1:0]         main_bandwidth_q,
    output logic                         phase_offset_apply_q,
    output logic [`MSR_OFS_W-1:0]        phase_offset_q,
    output logic [2*N_OUT-1:0]           align_mode_q
);
    import msr_pkg::*;

    logic                  role_lvl;
    logic                  sw_revertive_enable_q;
    logic                  sw_phase_buildout_enable_q;
    logic                  sw_monitor_buildout_enable_q;
    logic [7:0]            sw_input_priority_reg_six_q;
    logic [`MSR_BW_W-1:0]  sw_abw_q;
    logic [`MSR_BW_W-1:0]  sw_lbw_q;
    logic [`MSR_OFS_W-1:0] sw_offset_q;
    logic                  dp_act_q;
    logic                  dp_wr_q;
    logic [7:0]            dp_addr_q;
    msr_role_t             role;
    logic                  phase_buildout_enable_eff;
    logic                  revertive_enable_eff;
    logic [`MSR_PRI_W-1:0] input_eleven_priority_eff;
    logic [`MSR_BW_W-1:0]  bw_eff;
    logic [31:0]           rd_mux;
    logic                  wr_main_config_reg_three;
    logic                  wr_main_config_reg_ten;
    logic                  wr_phase_monitor_reg;
    logic                  wr_input_priority_reg_six;
    logic                  wr_abw;
    logic                  wr_lbw;
    logic                  wr_offset;
    logic [2*N_OUT-1:0]    mode_all;

    // Role pin sync.
    msr_role_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (role_select_pin),
        .level_q (role_lvl)
    );

    assign role = role_lvl ? MSR_ROLE_MASTER : MSR_ROLE_SLAVE;

    assign input_eleven_priority_eff = (role == MSR_ROLE_SLAVE) ? `MSR_PRI_SLAVE
                     : sw_input_priority_reg_six_q[`MSR_INPUT_PRIORITY_REG_SIX_INPUT_ELEVEN_PRIORITY_LSB +: `MSR_PRI_W];
    assign phase_buildout_enable_eff = (role == MSR_ROLE_SLAVE) ? 1'b0 : sw_phase_buildout_enable_q;
    assign revertive_enable_eff = (role == MSR_ROLE_SLAVE) ? 1'b1 : sw_revertive_enable_q;
    assign bw_eff = (role == MSR_ROLE_SLAVE) ? sw_abw_q : sw_lbw_q;

    // AHB-Lite address phase capture; zero wait states.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_act_q  <= 1'b0;
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else if (hready) begin
            dp_act_q  <= hsel && htrans[1];
            dp_wr_q   <= hwrite;
            dp_addr_q <= haddr;
        end
    end

    // Write strobes come from the captured address phase; the role bit has no strobe.
    assign wr_main_config_reg_three   = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_MAIN_CONFIG_REG_THREE);
    assign wr_main_config_reg_ten  = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_MAIN_CONFIG_REG_TEN);
    assign wr_phase_monitor_reg  = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_PHASE_MONITOR_REG);
    assign wr_input_priority_reg_six   = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_INPUT_PRIORITY_REG_SIX);
    assign wr_abw    = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_ABW);
    assign wr_lbw    = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_LBW);
    assign wr_offset = dp_act_q && dp_wr_q && (dp_addr_q == `MSR_OFF_OFFSET);

    // Software copies are kept in every role so that they return when forcing ends.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_revertive_enable_q <= `MSR_RST_REVERTIVE_ENABLE;
        end else if (wr_main_config_reg_three) begin
            sw_revertive_enable_q <= hwdata[`MSR_MAIN_CONFIG_REG_THREE_REVERTIVE_ENABLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_phase_buildout_enable_q <= `MSR_RST_PHASE_BUILDOUT_ENABLE;
        end else if (wr_main_config_reg_ten) begin
            sw_phase_buildout_enable_q <= hwdata[`MSR_MAIN_CONFIG_REG_TEN_PHASE_BUILDOUT_ENABLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_monitor_buildout_enable_q <= `MSR_RST_MONITOR_BUILDOUT_ENABLE;
        end else if (wr_phase_monitor_reg) begin
            sw_monitor_buildout_enable_q <= hwdata[`MSR_PHASE_MONITOR_REG_MONITOR_BUILDOUT_ENABLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_input_priority_reg_six_q <= `MSR_RST_INPUT_PRIORITY_REG_SIX;
        end else if (wr_input_priority_reg_six) begin
            sw_input_priority_reg_six_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_abw_q <= `MSR_RST_ABW;
        end else if (wr_abw) begin
            sw_abw_q <= hwdata[`MSR_BW_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_lbw_q <= `MSR_RST_LBW;
        end else if (wr_lbw) begin
            sw_lbw_q <= hwdata[`MSR_BW_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_offset_q <= `MSR_RST_OFFSET;
        end else if (wr_offset) begin
            sw_offset_q <= hwdata[`MSR_OFS_W-1:0];
        end
    end

    // Read view shows the effective, role-dependent values.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr)
            `MSR_OFF_MAIN_CONFIG_REG_THREE: begin
                rd_mux[`MSR_MAIN_CONFIG_REG_THREE_REVERTIVE_ENABLE] = revertive_enable_eff;
                rd_mux[`MSR_MAIN_CONFIG_REG_THREE_ROLE]   = role_lvl;
            end
            `MSR_OFF_MAIN_CONFIG_REG_TEN:  rd_mux[`MSR_MAIN_CONFIG_REG_TEN_PHASE_BUILDOUT_ENABLE] = phase_buildout_enable_eff;
            `MSR_OFF_PHASE_MONITOR_REG:  rd_mux[`MSR_PHASE_MONITOR_REG_MONITOR_BUILDOUT_ENABLE] = sw_monitor_buildout_enable_q;
            `MSR_OFF_INPUT_PRIORITY_REG_SIX:   rd_mux[7:0] = {input_eleven_priority_eff, sw_input_priority_reg_six_q[3:0]};
            `MSR_OFF_ABW:    rd_mux[`MSR_BW_W-1:0] = sw_abw_q;
            `MSR_OFF_LBW:    rd_mux[`MSR_BW_W-1:0] = sw_lbw_q;
            `MSR_OFF_OFFSET: rd_mux[`MSR_OFS_W-1:0] = sw_offset_q;
            `MSR_OFF_EFFECT: rd_mux[`MSR_BW_W-1:0] = bw_eff;
            `MSR_OFF_ALIGN:  rd_mux[2*N_OUT-1:0] = align_mode_q;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is taken at the accepted address phase so that it stands in the data phase.
    // A read issued right behind a write to the same word still returns the older value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            role_master_q <= 1'b0;
        end else begin
            role_master_q <= role_lvl;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_eleven_priority_q <= `MSR_PRI_SLAVE;
        end else begin
            input_eleven_priority_q <= input_eleven_priority_eff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_buildout_enable_q <= 1'b0;
        end else begin
            phase_buildout_enable_q <= phase_buildout_enable_eff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            monitor_buildout_enable_q <= 1'b0;
        end else begin
            monitor_buildout_enable_q <= sw_monitor_buildout_enable_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            revertive_enable_q <= 1'b1;
        end else begin
            revertive_enable_q <= revertive_enable_eff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_bandwidth_q <= `MSR_RST_ABW;
        end else begin
            main_bandwidth_q <= bw_eff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_offset_apply_q <= 1'b1;
        end else begin
            phase_offset_apply_q <= !phase_buildout_enable_eff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_offset_q <= `MSR_RST_OFFSET;
        end else begin
            phase_offset_q <= sw_offset_q;
        end
    end

    // Per-output alignment class against the selected reference frequency.
    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi++) begin : g_align
            logic [F_W-1:0] fo;
            logic           locked;
            logic           submult;
            msr_align_t     mode;
            assign fo     = out_freq[gi*F_W +: F_W];
            assign locked = out_from_aux[gi] ? aux_locked : main_locked;
            assign submult = (fo != '0) && ((ref_freq % fo) == '0);
            always_comb begin
                mode = MSR_ALIGN_NONE;
                if (locked && !phase_buildout_enable_eff && ref_freq != '0) begin
                    if (fo == ref_freq) begin
                        mode = MSR_ALIGN_PHASE;
                    end else if (fo > ref_freq) begin
                        mode = MSR_ALIGN_FALLING;
                    end else if (submult) begin
                        mode = MSR_ALIGN_SUBMULT;
                    end
                end
            end
            assign mode_all[2*gi +: 2] = mode;
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            align_mode_q <= '0;
        end else begin
            align_mode_q <= mode_all;
        end
    end
endmodule

// >>> testbench/msr_redundancy_chk.sv
// Concurrent assertions for the redundancy control block.
`timescale 1ns/1ps
module msr_redundancy_chk #(
    parameter int N_OUT = 8,
    parameter int F_W   = 16
) (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [7:0]         haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic [31:0]        hrdata,
    input wire logic               role_select_pin,
    input wire logic               main_locked,
    input wire logic               aux_locked,
    input wire logic               role_master_q,
    input wire logic [3:0]         input_eleven_priority_q,
    input wire logic               phase_buildout_enable_q,
    input wire logic               revertive_enable_q,
    input wire logic               phase_offset_apply_q,
    input wire logic [2*N_OUT-1:0] align_mode_q
);
    logic rd_cfg_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_cfg_q <= 1'b0;
        end else begin
            rd_cfg_q <= hsel && htrans[1] && !hwrite && hready && haddr == 8'h00;
        end
    end
    a_role_high: assert property (role_select_pin [*8] |-> role_master_q)
        else $error("role not master after steady high pin");
    a_role_low: assert property (!role_select_pin [*8] |-> !role_master_q)
        else $error("role not slave after steady low pin");
    a_sync_delay: assert property ($rose(role_select_pin) && !role_master_q |-> ##1 !role_master_q)
        else $error("role followed pin without synchronising");
    a_slave_prio: assert property (!role_master_q [*3] |-> input_eleven_priority_q == 4'h1)
        else $error("slave priority not forced");
    a_slave_pbo: assert property (!role_master_q [*3] |-> !phase_buildout_enable_q)
        else $error("slave build-out not forced off");
    a_slave_rev: assert property (!role_master_q |-> revertive_enable_q)
        else $error("slave revertive not forced on");
    a_offset_apply: assert property (!phase_buildout_enable_q [*2] |-> phase_offset_apply_q)
        else $error("offset not applied with build-out off");
    a_align_lock: assert property ((!main_locked && !aux_locked) [*2] |-> align_mode_q == '0)
        else $error("alignment without lock");
    a_align_pbo: assert property (phase_buildout_enable_q [*2] |-> align_mode_q == '0)
        else $error("alignment with build-out on");
    a_role_read: assert property (rd_cfg_q |-> hrdata[1] == role_master_q || hrdata[1] == $past(role_master_q))
        else $error("role bit read wrong");
endmodule
bind msr_redundancy msr_redundancy_chk #(.N_OUT(N_OUT), .F_W(F_W)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .role_select_pin(role_select_pin),
    .main_locked(main_locked), .aux_locked(aux_locked), .role_master_q(role_master_q),
    .input_eleven_priority_q(input_eleven_priority_q),
    .phase_buildout_enable_q(phase_buildout_enable_q), .revertive_enable_q(revertive_enable_q),
    .phase_offset_apply_q(phase_offset_apply_q), .align_mode_q(align_mode_q));

// >>> testbench/msr_peer_model.sv
// Peer timing card that drives the cross-wired role pin.
`timescale 1ns/1ps
module msr_peer_model (
    input  wire logic        hclk,
    input  wire logic        peer_master,
    input  wire logic        both_high,
    input  wire logic [15:0] peer_invalid,
    output logic             role_select_pin,
    output logic [15:0]      invalid_mark
);
    always_ff @(posedge hclk) begin
        invalid_mark <= peer_invalid;
    end

    always_ff @(posedge hclk) begin
        role_select_pin <= both_high || !peer_master;
    end
endmodule

// >>> testbench/tb_msr_redundancy.sv
// Self-checking testbench of the redundancy control block.
`timescale 1ns/1ps
module tb_msr_redundancy;
    logic         hclk, hresetn, hsel, hwrite, rdy, pm, bh, lk, pin, role, rd_ph, apply;
    logic         resp, pbo, mbo, rev, alk;
    logic [7:0]   fa;
    logic [15:0]  inv, invm;
    logic [7:0]   haddr;
    logic [1:0]   htrans;
    logic [31:0]  hwdata, hrdata;
    logic [15:0]  rnd, ofs, amode;
    logic [3:0]   pri;
    logic [4:0]   bw, abw;
    logic [31:0]  exp_q[$];
    logic [7:0]   ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h3c};
    logic [31:0]  rv[7] = '{32'h1, 32'h0, 32'h10, 32'h0, 32'h1, 32'h0, 32'h0};
    int           mismatches, cmp_count;
    msr_peer_model u_peer (.hclk(hclk), .peer_master(pm), .both_high(bh), .peer_invalid(inv),
        .role_select_pin(pin), .invalid_mark(invm));
    msr_redundancy DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
        .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .role_select_pin(pin), .main_locked(lk),
        .aux_locked(alk), .ref_freq(16'h0064), .out_freq({{5{16'h0007}}, 48'h003200c80064}),
        .out_from_aux(fa), .role_master_q(role), .input_eleven_priority_q(pri),
        .phase_buildout_enable_q(pbo), .monitor_buildout_enable_q(mbo), .revertive_enable_q(rev),
        .main_bandwidth_q(bw), .phase_offset_apply_q(apply), .phase_offset_q(ofs),
        .align_mode_q(amode));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) exp_q.push_back(d);
        do @(posedge hclk); while (rdy !== 1'b1);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (rd_ph) chk(hrdata, exp_q.pop_front());
        rd_ph <= hsel && htrans[1] && !hwrite && rdy;
    end
    initial begin
        repeat (3000) @(posedge hclk);
        mismatches++;
        conclude();
    end
    initial begin
        {hresetn, hsel, hwrite, lk, bh, alk, fa, inv, haddr, htrans, hwdata} = '0;
        pm = 1'b1;
        rnd = 16'he295;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        foreach (ra[i]) bus(1'b0, ra[i], rv[i]);
        $display("reset values done");
        rnd = lfsr(rnd);
        abw = {1'b1, rnd[3:0]};
        foreach (ra[i]) bus(1'b1, ra[i] + 8'h04 * (i == 3), {rnd[10:0], 5'h00, rnd} ^ 32'ha5);
        bus(1'b1, 8'h08, 32'ha5);
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b1, 8'h0c, {27'h0, abw});
        bus(1'b1, 8'h18, {16'h0, rnd});
        bus(1'b1, 8'h10, {27'h0, 1'b0, abw[3:0] ^ 4'h5});
        bus(1'b1, 8'h14, 32'h0);
        bus(0, 8'h08, 32'h15);
        bus(0, 8'h04, 32'h0);
        bus(0, 8'h00, 32'h1);
        bus(0, 8'h1c, {27'h0, abw});
        lk <= 1'b1;
        inv <= rnd;
        repeat (3) @(posedge hclk);
        chk(bw, abw);
        chk(role, 1'b0);
        chk(pbo, 1'b0);
        chk(rev, 1'b1);
        chk(mbo, 1'b0);
        chk(resp, 1'b0);
        chk(invm, rnd);
        chk(pri, 4'h1);
        chk(apply, 1'b1);
        chk(ofs, rnd);
        chk(amode, 16'h0039);
        fa <= 8'h01;
        repeat (3) @(posedge hclk);
        chk(amode, 16'h0038);
        alk <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(amode, 16'h0039);
        $display("slave role done");
        pm <= 1'b0;
        repeat (10) @(posedge hclk);
        chk(role, 1'b1);
        chk(amode, 16'h0000);
        chk(pbo, 1'b1);
        chk(rev, 1'b0);
        bus(0, 8'h08, 32'ha5);
        bus(1'b1, 8'h08, 32'h05);
        bus(0, 8'h08, 32'h05);
        bus(0, 8'h04, 32'h1);
        bus(0, 8'h00, 32'h2);
        bus(0, 8'h1c, {27'h0, 1'b0, abw[3:0] ^ 4'h5});
        $display("master role done");
        bh <= 1'b1;
        pm <= 1'b1;
        repeat (10) @(posedge hclk);
        bus(0, 8'h00, 32'h2);
        bus(1'b1, 8'h00, 32'h1);
        bus(0, 8'h00, 32'h3);
        bh <= 1'b0;
        repeat (10) @(posedge hclk);
        bus(0, 8'h08, 32'h15);
        bus(0, 8'h3c, 32'h0);
        $display("role return done");
        conclude();
    end
endmodule
